// [sbrg_top.sv]
// Functional notes
// R1 - Receive level is majority of three samples; the code votes only in asynchronous mode, synchronous uses the synced pin
// R2 - Rate is clock over factor times divisor+1
// R3 - Synchronous mode ignores the high speed bit
// R4 - Generator runs from the system clock
// R5 - Software rewrites divisor after clock change
// R6 - Divisor lives in its own register
// R7 - Dedicated free-running 8-bit timer
// R8 - Divisor write resets the timer at once
// R9 - Synchronous slave takes no rate from generator
// R10 - Timer ticks every divisor+1, then fixed prescale
`timescale 1ns/1ps
module sbrg_top
  import sbrg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial side
  input  wire logic        serial_receive_pin_i,
  output logic             rx_level_o,
  output logic             gen_tick_o,
  output logic             bit_tick_o
);
  import sbrg_pkg::*;

  logic [7:0]  transmit_control_status;
  logic [7:0]  receive_control_status;
  logic [7:0]  rate_divisor;
  logic [5:0]  pre_cnt;
  logic [31:0] next_rdata;
  logic        bus_req;
  logic        wr_take;
  logic        div_wr;
  logic        pre_wrap;
  sbrg_mode_t  mode;
  logic [5:0]  pre_last;

  // Request is held until ack; a write lands on the edge that sees ack
  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign wr_take  = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign div_wr   = wr_take && (wb_adr_i == ADR_DIV);
  assign mode     = sbrg_mode(transmit_control_status);
  assign pre_last = sbrg_pre_last(mode);
  assign pre_wrap = pre_cnt >= pre_last;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'h0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // Transmit control: only the low lane carries a register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      transmit_control_status <= TX_RST;
    end else if (wr_take && wb_adr_i == ADR_TX_CTL) begin
      transmit_control_status <= wb_dat_i[7:0] & TX_WR_MASK;
    end
  end

  // Receive control; status bits belong to the receiver and read zero here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      receive_control_status <= RX_RST;
    end else if (wr_take && wb_adr_i == ADR_RX_CTL) begin
      receive_control_status <= wb_dat_i[7:0] & RX_WR_MASK;
    end
  end

  // Divisor has a register of its own, apart from both controls
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_divisor <= DIV_RST;
    end else if (div_wr) begin
      rate_divisor <= wb_dat_i[7:0];  // [R6]
    end
  end

  // Read decode; unmapped addresses answer with zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (wb_adr_i == ADR_TX_CTL) begin
      next_rdata[7:0] = transmit_control_status;
      next_rdata[TX_EMPTY_BIT] = 1'h1;  // No shifter here, always empty
    end else if (wb_adr_i == ADR_RX_CTL) begin
      next_rdata[7:0] = receive_control_status;
    end else if (wb_adr_i == ADR_DIV) begin
      next_rdata[7:0] = rate_divisor;
    end else if (wb_adr_i == ADR_STAT) begin
      next_rdata[7:0] = {pre_cnt, 1'h0, rx_level_o};
    end
  end

  // Read data captured with the ack
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Timer counts system clocks, so the rate scales with the clock source
  sbrg_rate_timer u_timer (
    .clk_i      (clk_i),             // [R4]
    .rst_n_i    (rst_n_i),
    .load_i     (div_wr),            // [R8]
    .load_val_i (wb_dat_i[7:0]),
    .div_i      (rate_divisor),      // [R7]
    .tick_o     (gen_tick_o)
  );

  // Majority sampling only in asynchronous mode
  sbrg_majority u_sample (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .pin_i       (serial_receive_pin_i),
    .sample_en_i (gen_tick_o),
    .vote_en_i   (!transmit_control_status[TX_SYNC_BIT]),  // [R1]
    .level_o     (rx_level_o)
  );

  // Prescaler; >= lets a mode change to a smaller factor wrap at once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt <= 6'h00;
    end else if (div_wr) begin
      pre_cnt <= 6'h00;               // [R8]
    end else if (gen_tick_o) begin
      pre_cnt <= pre_wrap ? 6'h00 : pre_cnt + 6'h01;  // [R10] [R2]
    end
  end

  // Bit rate tick; a synchronous slave is clocked from outside
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_tick_o <= 1'h0;
    end else begin
      bit_tick_o <= gen_tick_o && pre_wrap && (mode != SBRG_SYNC_SLAVE);  // [R2] [R3] [R9]
    end
  end

  // Helpers for assertions: gap between timer ticks and write tracking
  logic [8:0] gap_cnt;
  logic       tick_seen;
  logic       after_wr;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_cnt   <= 9'h000;
      tick_seen <= 1'h0;
      after_wr  <= 1'h0;
    end else begin
      if (div_wr || gen_tick_o) begin
        gap_cnt <= 9'h001;
      end else if (gap_cnt != 9'h1FF) begin
        gap_cnt <= gap_cnt + 9'h001;
      end
      if (div_wr) begin
        tick_seen <= 1'h0;
        after_wr  <= 1'h1;
      end else if (gen_tick_o) begin
        tick_seen <= 1'h1;
        after_wr  <= 1'h0;
      end
    end
  end

  chk_tick_period: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10] [R7] [R4]
    (gen_tick_o && tick_seen) |-> gap_cnt == {1'h0, rate_divisor} + 9'h001)
    else $error("timer tick spacing is not divisor plus one");

  chk_write_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
    (gen_tick_o && after_wr) |-> gap_cnt == {1'h0, rate_divisor} + 9'h002)
    else $error("first tick after divisor write is late or early");

  chk_bit_needs_tick: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
    bit_tick_o |-> $past(gen_tick_o) && $past(pre_wrap))
    else $error("bit tick without terminal prescale");

  chk_low_factor: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
    (mode == SBRG_ASYNC_LO && gen_tick_o && pre_cnt < PRE_LO_LAST) |=> !bit_tick_o)
    else $error("low speed bit tick before 64 ticks");

  chk_sync_factor: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
    (mode == SBRG_SYNC_MASTER && gen_tick_o && !div_wr && pre_cnt == PRE_SYNC_LAST)
      |=> (bit_tick_o && pre_cnt == 6'h00))
    else $error("synchronous factor is not 4");

  chk_slave_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
    (mode == SBRG_SYNC_SLAVE) |=> !bit_tick_o)
    else $error("bit tick while synchronous slave");

  chk_div_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
    div_wr |=> (rate_divisor == $past(wb_dat_i[7:0])
      && transmit_control_status == $past(transmit_control_status)))
    else $error("divisor write misrouted");

  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  cov_async_hi_bit: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == SBRG_ASYNC_HI && bit_tick_o);

  cov_sync_bit: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == SBRG_SYNC_MASTER && bit_tick_o);

  cov_write_restart: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    gen_tick_o && after_wr);

  cov_async_lo_bit: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == SBRG_ASYNC_LO && bit_tick_o);

  cov_slave_tick: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == SBRG_SYNC_SLAVE && gen_tick_o);

  // High speed must not wrap early; 16 timer ticks make one bit
  chk_hi_factor: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
    (mode == SBRG_ASYNC_HI && gen_tick_o && pre_cnt < PRE_HI_LAST) |=> !bit_tick_o)
    else $error("high speed bit tick before 16 ticks");

  // Low speed wraps exactly at its last count
  chk_lo_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
    (mode == SBRG_ASYNC_LO && gen_tick_o && !div_wr && pre_cnt == PRE_LO_LAST)
      |=> (bit_tick_o && pre_cnt == 6'h00))
    else $error("low speed factor is not 64");

  // High speed wraps exactly at its last count
  chk_hi_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
    (mode == SBRG_ASYNC_HI && gen_tick_o && !div_wr && pre_cnt == PRE_HI_LAST)
      |=> (bit_tick_o && pre_cnt == 6'h00))
    else $error("high speed factor is not 16");

  // A divisor write restarts the prescale too, else the first bit would be short
  chk_write_clears_pre: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
    div_wr |=> pre_cnt == 6'h00)
    else $error("prescale not cleared by divisor write");

  // Every request gets its ack in the next cycle
  chk_ack_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (bus_req && !wb_ack_o) |=> wb_ack_o)
    else $error("ack did not follow request");

  // No ack without a request on the bus
  chk_idle_no_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !bus_req |=> !wb_ack_o)
    else $error("ack without request");

  // A write on a closed byte lane must leave all registers alone
  chk_lane_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
    (bus_req && wb_we_i && wb_ack_o && !wb_sel_i[0])
      |=> ($stable(rate_divisor) && $stable(transmit_control_status) && $stable(receive_control_status)))
    else $error("write with closed lane changed a register");

  // Divisor reads back from its own register
  chk_read_div: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R6]
    (bus_req && !wb_we_i && !wb_ack_o && wb_adr_i == ADR_DIV)
      |=> wb_dat_o == {24'h000000, $past(rate_divisor)})
    else $error("divisor read data wrong");

  // No shifter lives here, so software always sees it empty
  chk_empty_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (bus_req && !wb_we_i && !wb_ack_o && wb_adr_i == ADR_TX_CTL) |=> wb_dat_o[TX_EMPTY_BIT])
    else $error("transmit empty bit read low");

  // Status shows the resolved receive level
  chk_status_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
    (bus_req && !wb_we_i && !wb_ack_o && wb_adr_i == ADR_STAT) |=> wb_dat_o[0] == $past(rx_level_o))
    else $error("status level differs from receive level");

endmodule

// [sbrg_pkg.sv]
package sbrg_pkg;

  // Register byte addresses on the bus
  localparam logic [7:0] ADR_TX_CTL = 8'h00;
  localparam logic [7:0] ADR_RX_CTL = 8'h04;
  localparam logic [7:0] ADR_DIV    = 8'h08;
  localparam logic [7:0] ADR_STAT   = 8'h0C;

  // Field positions in transmit_control_status
  localparam int TX_MASTER_BIT = 7;
  localparam int TX_SYNC_BIT   = 4;
  localparam int TX_HS_BIT     = 2;
  localparam int TX_EMPTY_BIT  = 1;

  // Writable bits; transmit bit 3 is unimplemented, bit 1 is read-only
  localparam logic [7:0] TX_WR_MASK = 8'hF5;
  localparam logic [7:0] RX_WR_MASK = 8'hF8;

  // Values after reset
  localparam logic [7:0] TX_RST  = 8'h00;
  localparam logic [7:0] RX_RST  = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic       RX_IDLE = 1'h1;

  // Prescale terminal counts: factor minus one
  localparam logic [5:0] PRE_LO_LAST   = 6'h3F;
  localparam logic [5:0] PRE_HI_LAST   = 6'h0F;
  localparam logic [5:0] PRE_SYNC_LAST = 6'h03;

  typedef enum logic [1:0] {
    SBRG_ASYNC_LO,
    SBRG_ASYNC_HI,
    SBRG_SYNC_MASTER,
    SBRG_SYNC_SLAVE
  } sbrg_mode_t;

  // Mode from transmit control; high speed only matters when asynchronous
  function automatic sbrg_mode_t sbrg_mode(input logic [7:0] tx);
    if (tx[TX_SYNC_BIT]) begin
      return tx[TX_MASTER_BIT] ? SBRG_SYNC_MASTER : SBRG_SYNC_SLAVE;
    end
    return tx[TX_HS_BIT] ? SBRG_ASYNC_HI : SBRG_ASYNC_LO;
  endfunction

  // Last prescale count for each mode
  function automatic logic [5:0] sbrg_pre_last(input sbrg_mode_t m);
    case (m)
      SBRG_ASYNC_LO: return PRE_LO_LAST;
      SBRG_ASYNC_HI: return PRE_HI_LAST;
      default:       return PRE_SYNC_LAST;
    endcase
  endfunction

endpackage

// [sbrg_rate_timer.sv]
`timescale 1ns/1ps
module sbrg_rate_timer (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Divisor and reload strobe
  input  wire logic       load_i,
  input  wire logic [7:0] load_val_i,
  input  wire logic [7:0] div_i,
  // One pulse per divisor + 1 clocks
  output logic            tick_o
);
  import sbrg_pkg::*;

  logic [7:0] count;

  // Down counter; a write reloads at once instead of waiting for zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= DIV_RST;
    end else if (load_i) begin
      count <= load_val_i;          // [R8]
    end else if (count == 8'h00) begin
      count <= div_i;               // [R10] [R7]
    end else begin
      count <= count - 8'h01;
    end
  end

  // Tick is registered so it reaches the port glitch free
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'h0;
    end else begin
      tick_o <= !load_i && (count == 8'h00);  // [R10]
    end
  end

  chk_reload_value: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
    load_i |=> count == $past(load_val_i))
    else $error("timer did not reload the written divisor");

  chk_zero_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
    (!load_i && count == 8'h00) |=> (tick_o && count == $past(div_i)))
    else $error("timer missed tick or reload at zero");

endmodule

// [sbrg_majority.sv]
`timescale 1ns/1ps
module sbrg_majority (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Raw pin and sampling controls
  input  wire logic pin_i,
  input  wire logic sample_en_i,
  input  wire logic vote_en_i,
  // Resolved receive level
  output logic      level_o
);
  import sbrg_pkg::*;

  logic       sync1;
  logic       sync2;
  logic [2:0] hist;

  function automatic logic vote3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // Two flops against metastability on the pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= RX_IDLE;
      sync2 <= RX_IDLE;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
    end
  end

  // Last three samples, taken on generator ticks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist <= {3{RX_IDLE}};
    end else if (sample_en_i) begin
      hist <= {hist[1:0], sync2};   // [R1]
    end
  end

  // Vote in asynchronous mode; a single noisy sample cannot flip the level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= RX_IDLE;
    end else begin
      level_o <= vote_en_i ? vote3(hist) : sync2;  // [R1]
    end
  end

  chk_vote_high: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
    (vote_en_i && $countones(hist) >= 2) |=> level_o)
    else $error("two high samples did not give high");

  chk_vote_low: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
    (vote_en_i && $countones(hist) <= 1) |=> !level_o)
    else $error("two low samples did not give low");

endmodule

// [sbrg_remote_dev.sv]
`timescale 1ns/1ps
module sbrg_remote_dev (
  // Clock
  input  wire logic       clk_i,
  // 0 idle, 1 one-clock low spike, 2 held low
  input  wire logic [1:0] cmd_i,
  // Receive line toward the port
  output logic            line_o
);
  logic spiked;
  // Line idles at mark; a spike lasts one clock, so only one vote sample sees it
  initial begin
    line_o = 1'b1;
    spiked = 1'b0;
  end
  always @(posedge clk_i) begin
    if (cmd_i == 2'h2) begin
      line_o <= 1'b0;
    end else if (cmd_i == 2'h1 && !spiked) begin
      line_o <= 1'b0;
      spiked <= 1'b1;
    end else begin
      line_o <= 1'b1;
      spiked <= (cmd_i == 2'h1);
    end
  end
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb;
  import sbrg_pkg::*;
  logic        clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        serial_receive_pin_i, rx_level_o, gen_tick_o, bit_tick_o;
  logic [7:0]  wb_adr_i, v, d;
  logic [3:0]  wb_sel_i, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, r;
  logic [1:0]  cmd;
  int          num_errors, total_checks, cyc_cnt, seed, m, k, n;

  sbrg_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_receive_pin_i(serial_receive_pin_i),
    .rx_level_o(rx_level_o), .gen_tick_o(gen_tick_o), .bit_tick_o(bit_tick_o));
  sbrg_remote_dev far (.clk_i(clk_i), .cmd_i(cmd), .line_o(serial_receive_pin_i));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard: whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  // Only the hang guard ends a wait that never sees ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dt, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_v;
    wb_dat_i <= {24'h000000, dt};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, adr, 8'h00, q);
    chk(nm, {24'h000000, e}, q);
  endtask

  // Cycles from one tick to the next
  task automatic gap(input bit b, output int g);
    int w;
    w = 0;
    g = 0;
    while (((b ? bit_tick_o : gen_tick_o) !== 1'b1) && w < 2000) begin
      @(posedge clk_i);
      w++;
    end
    do begin
      @(posedge clk_i);
      g++;
    end while (((b ? bit_tick_o : gen_tick_o) !== 1'b1) && g < 2000);
  endtask

  // Control byte per mode: async low, async high, sync master with high speed set, sync slave
  function automatic logic [7:0] mode_tx(input int i);
    return (i == 0) ? 8'h00 : (i == 1) ? 8'h04 : (i == 2) ? 8'h94 : 8'h14;
  endfunction

  function automatic int fac(input int i);
    return (i == 0) ? 64 : (i == 1) ? 16 : 4;
  endfunction

  initial begin
    seed = 16144;
    {num_errors, total_checks, cyc_cnt} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, cmd} = '0;
    wb_sel_i = 4'hF;
    sel_v    = 4'hF;
    rst_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset state and register map
    rd_chk("tx_reset", ADR_TX_CTL, TX_RST | 8'h02);
    rd_chk("rx_reset", ADR_RX_CTL, RX_RST);
    rd_chk("div_reset", ADR_DIV, DIV_RST);
    rd_chk("unmapped", 8'h10, 8'h00);
    v = 8'($random(seed));
    wb(1'b1, ADR_DIV, v, r);
    wb(1'b1, ADR_RX_CTL, ~v, r);
    wb(1'b1, 8'h10, ~v, r);
    rd_chk("div_rw", ADR_DIV, v);
    rd_chk("rx_rw", ADR_RX_CTL, ~v & RX_WR_MASK);
    // Closed low byte lane: write is acked but ignored
    sel_v = 4'hE;
    wb(1'b1, ADR_DIV, ~v, r);
    sel_v = 4'hF;
    rd_chk("div_sel_off", ADR_DIV, v);
    // Every mode, random divisor, largest divisor as a corner
    for (m = 0; m < 4; m++) begin
      d = (m == 2) ? 8'hFF : 8'($random(seed) & 8'h07);
      wb(1'b1, ADR_TX_CTL, mode_tx(m), r);
      rd_chk("tx_rw", ADR_TX_CTL, (mode_tx(m) & TX_WR_MASK) | 8'h02);
      wb(1'b1, ADR_DIV, d, r);
      k = 0;
      do begin
        @(posedge clk_i);
        k++;
      end while (gen_tick_o !== 1'b1 && k < 600);
      chk("first_tick", d + 2, 32'(k));
      gap(1'b0, n);
      chk("gen_gap", d + 1, 32'(n));
      if (m < 3) begin
        gap(1'b1, n);
        chk("bit_gap", fac(m) * (d + 1), 32'(n));
      end else begin
        k = 0;
        repeat (300) begin
          @(posedge clk_i);
          if (bit_tick_o !== 1'b0) k++;
        end
        chk("slave_bits", 0, 32'(k));
      end
    end
    // Vote: a one-sample spike is outvoted, a held low wins
    wb(1'b1, ADR_TX_CTL, 8'h00, r);
    wb(1'b1, ADR_DIV, 8'h00, r);
    cmd <= 2'h1;
    k = 0;
    repeat (12) begin
      @(posedge clk_i);
      if (rx_level_o !== 1'b1) k++;
    end
    chk("spike_ignored", 0, 32'(k));
    cmd <= 2'h2;
    repeat (10) @(posedge clk_i);
    chk("rx_low", 0, 32'(rx_level_o));
    wb(1'b0, ADR_STAT, 8'h00, r);
    chk("status_rx", 0, r & 32'h00000001);
    // Synchronous mode has no vote, so the same spike shows for one cycle
    cmd <= 2'h0;
    wb(1'b1, ADR_TX_CTL, 8'h90, r);
    repeat (4) @(posedge clk_i);
    cmd <= 2'h1;
    k = 0;
    repeat (12) begin
      @(posedge clk_i);
      if (rx_level_o !== 1'b1) k++;
    end
    chk("sync_spike", 1, 32'(k));
    cmd <= 2'h0;
    end_sim();
  end
endmodule
